/* File: include/sgc_pkg.sv */
// Constants, attribute numbers and carrier types of the switchgear attribute map.
// Assumes one system clock at 250 MHz; attribute numbers are the network attribute IDs.
package sgc_pkg;
    localparam int SGC_CLK_MHZ = 250;
    localparam int SGC_STEP_US = 10000;
    localparam int SGC_STEP_CYCLES = SGC_STEP_US * SGC_CLK_MHZ;
    localparam int SGC_DEVICES = 4;
    localparam int SGC_POSITIONS = 6;
    localparam int SGC_POS_BITS = 2;

    localparam logic [7:0] SGC_ATTR_POS_FIRST = 8'h05;
    localparam logic [7:0] SGC_ATTR_MODE = 8'h0B;
    localparam logic [7:0] SGC_ATTR_CANCEL = 8'h0F;
    localparam logic [7:0] SGC_ATTR_LATCH_RESET = 8'h15;
    localparam logic [7:0] SGC_ATTR_MINUTE_SYNC = 8'h16;
    localparam logic [7:0] SGC_ATTR_POS_AMPS = 8'h1F;
    localparam logic [7:0] SGC_ATTR_NEG_AMPS = 8'h20;
    localparam logic [7:0] SGC_ATTR_RATIO = 8'h21;
    localparam logic [7:0] SGC_ATTR_ROTATION = 8'h22;
    localparam logic [7:0] SGC_ATTR_POS_VOLTS = 8'h23;
    localparam logic [7:0] SGC_ATTR_NEG_VOLTS = 8'h24;
    localparam logic [7:0] SGC_ATTR_OPEN [SGC_DEVICES] = '{8'h0C, 8'h11, 8'h17, 8'h1B};
    localparam logic [7:0] SGC_ATTR_CLOSE [SGC_DEVICES] = '{8'h0D, 8'h12, 8'h18, 8'h1C};
    localparam logic [7:0] SGC_ATTR_EXEC [SGC_DEVICES] = '{8'h0E, 8'h13, 8'h19, 8'h1D};
    localparam logic [7:0] SGC_ATTR_LIMIT [SGC_DEVICES] = '{8'h10, 8'h14, 8'h1A, 8'h1E};

    localparam logic [31:0] SGC_LIMIT_MIN [SGC_DEVICES] = '{32'h2, 32'h2, 32'h0, 32'h2};
    localparam logic [31:0] SGC_LIMIT_MAX = 32'h000927C0;
    localparam logic [31:0] SGC_LIMIT_RESET = 32'h0;
    localparam logic signed [31:0] SGC_ZERO = 32'sh0;
    localparam logic signed [31:0] SGC_VOLTS_MAX = 32'sh0006DDD0;
    localparam logic signed [31:0] SGC_RATIO_MAX = 32'sh00002710;
    localparam logic signed [31:0] SGC_SIGNED_MIN = 32'sh80000000;

    localparam logic SGC_MODE_REMOTE = 1'b0;
    localparam logic SGC_MODE_LOCAL = 1'b1;
    localparam logic [7:0] SGC_POS_OPEN = 8'h00;
    localparam logic [7:0] SGC_POS_CLOSED = 8'h01;
    localparam logic [7:0] SGC_POS_UNDEF = 8'h02;

    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] attr;
        logic [31:0] data;
    } sgc_req_type;

    typedef struct packed {
        logic valid;
        logic error;
        logic [31:0] data;
    } sgc_resp_type;

    typedef struct packed {
        logic signed [31:0] posSeqAmps;
        logic signed [31:0] negSeqAmps;
        logic signed [31:0] unbalance;
        logic [7:0] rotation;
        logic signed [31:0] posSeqVolts;
        logic signed [31:0] negSeqVolts;
    } sgc_meas_type;

    function automatic logic [31:0] sgcClamp(input logic signed [31:0] v,
                                             input logic signed [31:0] lo,
                                             input logic signed [31:0] hi);
        if (v < lo) begin
            return lo;
        end else if (v > hi) begin
            return hi;
        end
        return v;
    endfunction

    function automatic logic [7:0] sgcPosCode(input logic [1:0] pin);
        case (pin)
            2'h0: return SGC_POS_OPEN;
            2'h1: return SGC_POS_CLOSED;
            default: return SGC_POS_UNDEF;
        endcase
    endfunction
endpackage

/* File: rtl/sgc_sync.sv */
// Two-stage synchroniser for a bus of independent level signals.
// Assumes each bit is quasi-static; multi-bit words may be seen mid-change for one cycle.
`timescale 1ns/1ps
module sgc_sync #(
    parameter int WIDTH = 12
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [WIDTH-1:0] async,
    output logic [WIDTH-1:0] synced
);
    logic [WIDTH-1:0] meta;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            meta <= '0;
            synced <= '0;
        end else begin
            meta <= async;
            synced <= meta;
        end
    end
endmodule // sgc_sync

/* File: rtl/sgc_pulse_timer.sv */
// Control pulse generator for one switching device.
// Assumes start strobes come from the attribute map on the same clock, at most one at a time.
`timescale 1ns/1ps
module sgc_pulse_timer
    import sgc_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = SGC_STEP_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic startOpen,
    input wire logic startClose,
    input wire logic [31:0] limit,
    output logic driveOpen,
    output logic driveClose,
    output logic busy
);
    typedef enum logic {TM_IDLE, TM_DRIVE} sgc_tm_state_type;
    localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);

    sgc_tm_state_type state, next_state;
    logic [31:0] ticksLeft, next_ticksLeft;
    logic [31:0] preLeft, next_preLeft;
    logic next_driveOpen, next_driveClose;
    logic [31:0] heldLimit;
    logic [63:0] onCount;

    // Pulse lasts exactly limit steps; a zero limit gives no pulse at all
    always_comb begin
        next_state = state;
        next_ticksLeft = ticksLeft;
        next_preLeft = preLeft;
        next_driveOpen = driveOpen;
        next_driveClose = driveClose;
        case (state)
            TM_IDLE: begin
                if ((startOpen || startClose) && limit != '0) begin
                    next_state = TM_DRIVE;
                    next_ticksLeft = limit;
                    next_preLeft = TICK_LAST;
                    next_driveOpen = startOpen;
                    next_driveClose = startClose;
                end
            end
            TM_DRIVE: begin
                if (preLeft != '0) begin
                    next_preLeft = preLeft - 32'h1;
                end else if (ticksLeft == 32'h1) begin
                    next_state = TM_IDLE;
                    next_driveOpen = 1'b0;
                    next_driveClose = 1'b0;
                end else begin
                    next_ticksLeft = ticksLeft - 32'h1;
                    next_preLeft = TICK_LAST;
                end
            end
            default: begin
                next_state = TM_IDLE;
                next_driveOpen = 1'b0;
                next_driveClose = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state <= TM_IDLE;
            ticksLeft <= '0;
            preLeft <= '0;
            driveOpen <= 1'b0;
            driveClose <= 1'b0;
            busy <= 1'b0;
        end else begin
            state <= next_state;
            ticksLeft <= next_ticksLeft;
            preLeft <= next_preLeft;
            driveOpen <= next_driveOpen;
            driveClose <= next_driveClose;
            busy <= (next_state == TM_DRIVE);
        end
    end

    // Helper for the length check only
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            heldLimit <= '0;
            onCount <= '0;
        end else if (state == TM_IDLE && next_state == TM_DRIVE) begin
            heldLimit <= limit;
            onCount <= '0;
        end else if (driveOpen || driveClose) begin
            onCount <= onCount + 64'h1;
        end
    end

    property p_pulseBound;
        @(posedge clk_sys) disable iff (!rstn)
        (driveOpen || driveClose) |-> onCount < 64'(heldLimit) * 64'(TICK_CYCLES);
    endproperty
    a_pulseBound: assert property (p_pulseBound) else $error("control pulse longer than limit");

    property p_oneDirection;
        @(posedge clk_sys) disable iff (!rstn)
        !(driveOpen && driveClose);
    endproperty
    a_oneDirection: assert property (p_oneDirection) else $error("open and close driven together");
endmodule // sgc_pulse_timer

/* File: rtl/sgc_attribute_map.sv */
// Switchgear control attribute map: positions, control mode, select/execute/cancel,
// pulse limits, latch reset, minute sync and symmetrical-component readings.
// Assumes one attribute request per cycle from the network client on clk_sys;
// position pins are asynchronous, measurements come from logic on the same clock.
`timescale 1ns/1ps
module sgc_attribute_map
    import sgc_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = SGC_STEP_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire sgc_req_type attrReq,
    output sgc_resp_type attrResp,
    input wire logic [SGC_POSITIONS*SGC_POS_BITS-1:0] positionPins,
    input wire sgc_meas_type meas,
    output logic [SGC_DEVICES-1:0] driveOpen,
    output logic [SGC_DEVICES-1:0] driveClose,
    output logic controlLocal,
    output logic latchedOutputReset,
    output logic minuteSync
);
    logic rstnMeta;
    logic rstnSync;
    logic [SGC_POSITIONS*SGC_POS_BITS-1:0] posSync;
    logic mode, next_mode;
    logic [SGC_DEVICES-1:0] selOpen, next_selOpen;
    logic [SGC_DEVICES-1:0] selClose, next_selClose;
    logic [31:0] limit [SGC_DEVICES];
    logic [31:0] next_limit [SGC_DEVICES];
    logic next_latch, next_minute;
    logic [SGC_DEVICES-1:0] startOpen, startClose, busy;
    logic found, err, isLocal;
    logic [31:0] rdata;
    sgc_resp_type next_resp;

    // Reset release through two flops, assertion stays asynchronous
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rstnMeta <= 1'b0;
            rstnSync <= 1'b0;
        end else begin
            rstnMeta <= 1'b1;
            rstnSync <= rstnMeta;
        end
    end

    sgc_sync #(
        .WIDTH(SGC_POSITIONS * SGC_POS_BITS)
    ) u_posSync (
        .clk_sys(clk_sys),
        .rstn(rstnSync),
        .async(positionPins),
        .synced(posSync)
    );

    for (genvar g = 0; g < SGC_DEVICES; g++) begin : g_dev
        sgc_pulse_timer #(
            .TICK_CYCLES(TICK_CYCLES)
        ) u_timer (
            .clk_sys(clk_sys),
            .rstn(rstnSync),
            .startOpen(startOpen[g]),
            .startClose(startClose[g]),
            .limit(limit[g]),
            .driveOpen(driveOpen[g]),
            .driveClose(driveClose[g]),
            .busy(busy[g])
        );
    end

    always_comb begin
        next_mode = mode;
        next_selOpen = selOpen;
        next_selClose = selClose;
        next_limit = limit;
        next_latch = latchedOutputReset;
        next_minute = minuteSync;
        startOpen = '0;
        startClose = '0;
        found = 1'b0;
        err = 1'b0;
        rdata = '0;
        isLocal = (mode == SGC_MODE_LOCAL);
        if (attrReq.valid) begin
            for (int p = 0; p < SGC_POSITIONS; p++) begin
                if (attrReq.attr == SGC_ATTR_POS_FIRST + 8'(p)) begin
                    found = 1'b1;
                    err = attrReq.write;
                    rdata = {24'h0, sgcPosCode(posSync[p*SGC_POS_BITS +: SGC_POS_BITS])};
                end
            end
            for (int d = 0; d < SGC_DEVICES; d++) begin
                if (attrReq.attr == SGC_ATTR_OPEN[d]) begin
                    found = 1'b1;
                    rdata = {31'h0, selOpen[d]};
                    if (attrReq.write && isLocal) begin
                        err = 1'b1;
                    end else if (attrReq.write) begin
                        // A new selection replaces the opposite one
                        next_selOpen[d] = attrReq.data[0];
                        if (attrReq.data[0]) begin
                            next_selClose[d] = 1'b0;
                        end
                    end
                end
                if (attrReq.attr == SGC_ATTR_CLOSE[d]) begin
                    found = 1'b1;
                    rdata = {31'h0, selClose[d]};
                    if (attrReq.write && isLocal) begin
                        err = 1'b1;
                    end else if (attrReq.write) begin
                        next_selClose[d] = attrReq.data[0];
                        if (attrReq.data[0]) begin
                            next_selOpen[d] = 1'b0;
                        end
                    end
                end
                if (attrReq.attr == SGC_ATTR_EXEC[d]) begin
                    found = 1'b1;
                    if (!attrReq.write || isLocal) begin
                        err = 1'b1;
                    end else if (attrReq.data[0]) begin
                        // Execute without a selection, or during a pulse, is refused
                        if (!(selOpen[d] ^ selClose[d]) || busy[d]) begin
                            err = 1'b1;
                        end else begin
                            startOpen[d] = selOpen[d];
                            startClose[d] = selClose[d];
                            next_selOpen[d] = 1'b0;
                            next_selClose[d] = 1'b0;
                        end
                    end
                end
                if (attrReq.attr == SGC_ATTR_LIMIT[d]) begin
                    found = 1'b1;
                    rdata = limit[d];
                    if (attrReq.write) begin
                        // Out-of-range values keep the old limit
                        if (attrReq.data < SGC_LIMIT_MIN[d] || attrReq.data > SGC_LIMIT_MAX) begin
                            err = 1'b1;
                        end else begin
                            next_limit[d] = attrReq.data;
                        end
                    end
                end
            end
            case (attrReq.attr)
                SGC_ATTR_MODE: begin
                    found = 1'b1;
                    rdata = {31'h0, mode};
                    if (attrReq.write) begin
                        next_mode = attrReq.data[0];
                    end
                end
                SGC_ATTR_CANCEL: begin
                    found = 1'b1;
                    if (!attrReq.write || isLocal) begin
                        err = 1'b1;
                    end else if (attrReq.data[0]) begin
                        next_selOpen = '0;
                        next_selClose = '0;
                    end
                end
                SGC_ATTR_LATCH_RESET: begin
                    found = 1'b1;
                    rdata = {31'h0, latchedOutputReset};
                    if (attrReq.write) begin
                        next_latch = attrReq.data[0];
                    end
                end
                SGC_ATTR_MINUTE_SYNC: begin
                    found = 1'b1;
                    rdata = {31'h0, minuteSync};
                    if (attrReq.write) begin
                        next_minute = attrReq.data[0];
                    end
                end
                SGC_ATTR_POS_AMPS: begin
                    found = 1'b1;
                    err = attrReq.write;
                    rdata = sgcClamp(meas.posSeqAmps, SGC_ZERO, ~SGC_SIGNED_MIN);
                end
                SGC_ATTR_NEG_AMPS: begin
                    found = 1'b1;
                    err = attrReq.write;
                    rdata = meas.negSeqAmps;
                end
                SGC_ATTR_RATIO: begin
                    found = 1'b1;
                    err = attrReq.write;
                    rdata = sgcClamp(meas.unbalance, SGC_ZERO, SGC_RATIO_MAX);
                end
                SGC_ATTR_ROTATION: begin
                    found = 1'b1;
                    err = attrReq.write;
                    rdata = {24'h0, meas.rotation};
                end
                SGC_ATTR_POS_VOLTS: begin
                    found = 1'b1;
                    err = attrReq.write;
                    rdata = sgcClamp(meas.posSeqVolts, SGC_ZERO, SGC_VOLTS_MAX);
                end
                SGC_ATTR_NEG_VOLTS: begin
                    found = 1'b1;
                    err = attrReq.write;
                    rdata = sgcClamp(meas.negSeqVolts, SGC_ZERO, SGC_VOLTS_MAX);
                end
                default: begin
                end
            endcase
            if (!found) begin
                err = 1'b1;
            end
        end
        // Pending selections must not survive a change to local control
        if (next_mode == SGC_MODE_LOCAL) begin
            next_selOpen = '0;
            next_selClose = '0;
        end
        next_resp.valid = attrReq.valid;
        next_resp.error = err;
        next_resp.data = err ? '0 : rdata;
    end

    always_ff @(posedge clk_sys or negedge rstnSync) begin
        if (!rstnSync) begin
            mode <= SGC_MODE_REMOTE;
            selOpen <= '0;
            selClose <= '0;
            for (int d = 0; d < SGC_DEVICES; d++) begin
                limit[d] <= SGC_LIMIT_RESET;
            end
            latchedOutputReset <= 1'b0;
            minuteSync <= 1'b0;
            controlLocal <= SGC_MODE_REMOTE;
            attrResp <= '0;
        end else begin
            mode <= next_mode;
            selOpen <= next_selOpen;
            selClose <= next_selClose;
            limit <= next_limit;
            latchedOutputReset <= next_latch;
            minuteSync <= next_minute;
            controlLocal <= next_mode;
            attrResp <= next_resp;
        end
    end

    property p_localNoStart;
        @(posedge clk_sys) disable iff (!rstnSync)
        (mode == SGC_MODE_LOCAL) |-> (startOpen == '0 && startClose == '0);
    endproperty
    a_localNoStart: assert property (p_localNoStart) else $error("start issued in local mode");

    property p_localRefused;
        @(posedge clk_sys) disable iff (!rstnSync)
        (attrReq.valid && attrReq.write && mode == SGC_MODE_LOCAL && attrReq.attr == SGC_ATTR_OPEN[0])
        |=> (attrResp.valid && attrResp.error && selOpen[0] == 1'b0);
    endproperty
    a_localRefused: assert property (p_localRefused) else $error("local select write not refused");

    property p_limitOne;
        @(posedge clk_sys) disable iff (!rstnSync)
        $changed(limit[0]) |-> (limit[0] >= SGC_LIMIT_MIN[0] && limit[0] <= SGC_LIMIT_MAX);
    endproperty
    a_limitOne: assert property (p_limitOne) else $error("device one limit out of range");

    property p_limitThree;
        @(posedge clk_sys) disable iff (!rstnSync)
        (attrReq.valid && attrReq.write && attrReq.attr == SGC_ATTR_LIMIT[2] && attrReq.data <= SGC_LIMIT_MAX)
        |=> (limit[2] == $past(attrReq.data) && !attrResp.error);
    endproperty
    a_limitThree: assert property (p_limitThree) else $error("device three limit write lost");

    property p_posAmps;
        @(posedge clk_sys) disable iff (!rstnSync)
        (attrReq.valid && !attrReq.write && attrReq.attr == SGC_ATTR_POS_AMPS)
        |=> (!attrResp.error && $signed(attrResp.data) >= SGC_ZERO);
    endproperty
    a_posAmps: assert property (p_posAmps) else $error("positive sequence current negative");

    property p_negAmps;
        @(posedge clk_sys) disable iff (!rstnSync)
        (attrReq.valid && !attrReq.write && attrReq.attr == SGC_ATTR_NEG_AMPS)
        |=> (attrResp.data == $past(meas.negSeqAmps));
    endproperty
    a_negAmps: assert property (p_negAmps) else $error("negative sequence current altered");

    property p_posVolts;
        @(posedge clk_sys) disable iff (!rstnSync)
        (attrReq.valid && !attrReq.write && attrReq.attr == SGC_ATTR_POS_VOLTS)
        |=> ($signed(attrResp.data) >= SGC_ZERO && $signed(attrResp.data) <= SGC_VOLTS_MAX);
    endproperty
    a_posVolts: assert property (p_posVolts) else $error("positive sequence voltage out of range");

    property p_negVolts;
        @(posedge clk_sys) disable iff (!rstnSync)
        (attrReq.valid && !attrReq.write && attrReq.attr == SGC_ATTR_NEG_VOLTS)
        |=> ($signed(attrResp.data) <= SGC_VOLTS_MAX);
    endproperty
    a_negVolts: assert property (p_negVolts) else $error("negative sequence voltage above bound");

    property p_cancel;
        @(posedge clk_sys) disable iff (!rstnSync)
        (attrReq.valid && attrReq.write && attrReq.attr == SGC_ATTR_CANCEL && attrReq.data[0])
        |=> (selOpen == '0 && selClose == '0);
    endproperty
    a_cancel: assert property (p_cancel) else $error("cancel left a selection pending");
endmodule // sgc_attribute_map

/* File: tb/sgc_client_model.sv */
// Network client model: one attribute request at a time, answer collected.
// Assumes the caller runs on clk_sys; requests launch just after a rising edge.
`timescale 1ns/1ps
module sgc_client_model
    import sgc_pkg::*;
(
    input wire logic clk_sys,
    input wire sgc_resp_type attrResp,
    output sgc_req_type attrReq
);
    initial attrReq = '0;
    // Leading edge wait keeps two transfers from touching attrReq in one step
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output sgc_resp_type r);
        @(posedge clk_sys);
        #1;
        attrReq = '{1'b1, w, a, d};
        @(posedge clk_sys);
        #1;
        // Released fields inverted so stale values cannot pass
        attrReq = '{1'b0, ~w, ~a, ~d};
        r = attrResp;
    endtask
endmodule // sgc_client_model

/* File: tb/switchgear_control_attribute_map_bench.sv */
// Self-checking bench for the switchgear attribute map.
// Assumes the client model drives requests; pulse tick shortened to 4 cycles.
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module switchgear_control_attribute_map_bench
    import sgc_pkg::*;
;
    localparam int TICK = 4;
    typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic e; logic [31:0] x;} sgc_row_type;
    localparam sgc_row_type ROWS [29] = '{
        '{1'b0, 8'h05, 32'h0, 1'b0, 32'h0}, '{1'b0, 8'h06, 32'h0, 1'b0, 32'h1},
        '{1'b0, 8'h07, 32'h0, 1'b0, 32'h2}, '{1'b1, 8'h05, 32'h1, 1'b1, 32'h0},
        '{1'b0, 8'h1F, 32'h0, 1'b0, 32'h0},
        '{1'b0, 8'h20, 32'h0, 1'b0, 32'hFFFFFFF9},
        '{1'b0, 8'h23, 32'h0, 1'b0, 32'h0006DDD0},
        '{1'b0, 8'h24, 32'h0, 1'b0, 32'h7B},
        '{1'b0, 8'h21, 32'h0, 1'b0, 32'h2710}, '{1'b0, 8'h22, 32'h0, 1'b0, 32'h2},
        '{1'b1, 8'h20, 32'h1, 1'b1, 32'h0},
        '{1'b1, 8'h10, 32'h1, 1'b1, 32'h0},
        '{1'b1, 8'h10, 32'h2, 1'b0, 32'h0}, '{1'b0, 8'h10, 32'h0, 1'b0, 32'h2},
        '{1'b1, 8'h10, 32'h000927C1, 1'b1, 32'h0},
        '{1'b1, 8'h10, 32'h000927C0, 1'b0, 32'h2}, '{1'b0, 8'h10, 32'h0, 1'b0, 32'h000927C0},
        '{1'b1, 8'h1A, 32'h000927C1, 1'b1, 32'h0}, '{1'b0, 8'h1A, 32'h0, 1'b0, 32'h0},
        '{1'b1, 8'h1A, 32'h0, 1'b0, 32'h0},
        '{1'b1, 8'h14, 32'h1, 1'b1, 32'h0}, '{1'b1, 8'h1E, 32'h0, 1'b1, 32'h0},
        '{1'b0, 8'h0E, 32'h0, 1'b1, 32'h0}, '{1'b1, 8'h0E, 32'h1, 1'b1, 32'h0},
        '{1'b1, 8'h15, 32'h1, 1'b0, 32'h0}, '{1'b0, 8'h15, 32'h0, 1'b0, 32'h1},
        '{1'b1, 8'h16, 32'h1, 1'b0, 32'h0}, '{1'b0, 8'h16, 32'h0, 1'b0, 32'h1},
        '{1'b0, 8'h30, 32'h0, 1'b1, 32'h0}};
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    sgc_req_type attrReq;
    sgc_resp_type attrResp;
    sgc_resp_type r;
    logic [11:0] positionPins = 12'h024;
    sgc_meas_type meas = '{32'hFFFFFFFB, 32'hFFFFFFF9, 32'h00004E20, 8'h02, 32'h0007A120, 32'h0000007B};
    logic [3:0] driveOpen;
    logic [3:0] driveClose;
    logic controlLocal;
    logic latchedOutputReset;
    logic minuteSync;
    int n_mismatch = 0;
    int n_compared = 0;
    int cycles = 0;
    int len;

    always #2 clk_sys = ~clk_sys;

    sgc_client_model client (.clk_sys(clk_sys), .attrResp(attrResp), .attrReq(attrReq));
    sgc_attribute_map #(.TICK_CYCLES(TICK)) dut (.clk_sys(clk_sys), .rstn(rstn), .attrReq(attrReq),
        .attrResp(attrResp), .positionPins(positionPins), .meas(meas), .driveOpen(driveOpen),
        .driveClose(driveClose), .controlLocal(controlLocal), .latchedOutputReset(latchedOutputReset),
        .minuteSync(minuteSync));

    task automatic wrap_up;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic op(input logic w, input logic [7:0] a, input logic [31:0] d, input logic e, input logic [31:0] x);
        client.xfer(w, a, d, r);
        `CHK(r.valid, 1'b1)
        `CHK(r.error, e)
        `CHK(r.data, x)
    endtask

    // Ceiling well above the hundred or so cycles the tests need
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 2000) begin
            n_mismatch++;
            $display("timeout reached");
            wrap_up();
        end
    end

    initial begin
        repeat (2) @(posedge clk_sys);
        #1 rstn = 1'b1;
        `CHK({driveOpen, driveClose, controlLocal, latchedOutputReset, minuteSync}, 11'h000)
        repeat (2) @(posedge clk_sys);
        for (int i = 0; i < $size(ROWS); i++) begin
            op(ROWS[i].w, ROWS[i].a, ROWS[i].d, ROWS[i].e, ROWS[i].x);
        end
        `CHK(latchedOutputReset, 1'b1)
        `CHK(minuteSync, 1'b1)
        $display("table test done");
        op(1'b1, 8'h1A, 32'h2, 1'b0, 32'h0);
        op(1'b1, 8'h18, 32'h1, 1'b0, 32'h0);
        op(1'b1, 8'h0F, 32'h1, 1'b0, 32'h0);
        op(1'b1, 8'h19, 32'h1, 1'b1, 32'h0);
        op(1'b1, 8'h17, 32'h1, 1'b0, 32'h0);
        op(1'b1, 8'h19, 32'h1, 1'b0, 32'h0);
        `CHK(driveClose, 4'h0)
        len = 0;
        while (driveOpen[2] === 1'b1 && len < 100) begin
            len++;
            @(posedge clk_sys);
            #1;
        end
        `CHK(len, 2 * TICK)
        op(1'b1, 8'h19, 32'h1, 1'b1, 32'h0);
        op(1'b1, 8'h18, 32'h1, 1'b0, 32'h0);
        op(1'b1, 8'h19, 32'h1, 1'b0, 32'h0);
        `CHK(driveClose, 4'h4)
        // Second execute lands while the close pulse still runs
        op(1'b1, 8'h18, 32'h1, 1'b0, 32'h0);
        op(1'b1, 8'h19, 32'h1, 1'b1, 32'h0);
        $display("pulse test done");
        op(1'b1, 8'h0B, 32'h1, 1'b0, 32'h0);
        op(1'b1, 8'h0C, 32'h1, 1'b1, 32'h0);
        `CHK(controlLocal, 1'b1)
        op(1'b1, 8'h0E, 32'h1, 1'b1, 32'h0);
        // A write answers with the value it replaces
        op(1'b1, 8'h0B, 32'h0, 1'b0, 32'h1);
        op(1'b0, 8'h0C, 32'h0, 1'b0, 32'h0);
        `CHK(driveOpen, 4'h0)
        `CHK(driveClose, 4'h0)
        $display("local test done");
        wrap_up();
    end
endmodule // switchgear_control_attribute_map_bench
